// File: upssc_map.vh
`ifndef UPSSC_MAP_VH
`define UPSSC_MAP_VH
// register byte offsets
`define UPSSC_OFF_STATUS 8'h00
`define UPSSC_OFF_DATA 8'h04
`define UPSSC_OFF_CTRL1 8'h08
`define UPSSC_OFF_CTRL2 8'h0C
`define UPSSC_OFF_CTRL3 8'h10
// status bit positions
`define UPSSC_ST_TX_EMPTY 7
`define UPSSC_ST_TX_DONE 6
`define UPSSC_ST_RX_FULL 5
`define UPSSC_ST_QUIET 4
`define UPSSC_ST_OVERRUN 3
`define UPSSC_ST_NOISE 2
`define UPSSC_ST_FRAMING 1
`define UPSSC_ST_PARITY 0
// status reset value and clear groups
`define UPSSC_STATUS_RST 8'hC0
`define UPSSC_TX_GROUP 8'hC0
`define UPSSC_RX_GROUP 8'h3F
// ctrl1 bit positions
`define UPSSC_C1_NINE 4
`define UPSSC_C1_WAKE_ADDR 3
`define UPSSC_C1_PAR_ON 2
`define UPSSC_C1_PAR_ODD 1
`define UPSSC_C1_PAR_IRQ 0
// ctrl2 bit positions
`define UPSSC_C2_TX_EMPTY_IRQ 7
`define UPSSC_C2_TX_DONE_IRQ 6
`define UPSSC_C2_RX_IRQ 5
`define UPSSC_C2_QUIET_IRQ 4
`define UPSSC_C2_TX_ON 3
`define UPSSC_C2_RX_ON 2
`define UPSSC_C2_BREAK 0
// ctrl3 bit positions
`define UPSSC_C3_IDLE_LVL 2
`define UPSSC_C3_PHASE 1
`define UPSSC_C3_LAST 0
// clock cycles per serial bit
`define UPSSC_BIT_CYCLES 16
`endif

// File: upssc_parity.v
`timescale 1ns/10ps
module upssc_parity (
  // word and format
  input wire [8:0] WORD,
  input wire NINE,
  input wire ODD,
  // results
  output wire PAR,
  output wire MSB,
  output wire OK
);
  // odd parity flip
  // ones over the low 7 or 8 bits, flipped for odd parity
  assign PAR = (NINE ? ^WORD[7:0] : ^WORD[6:0]) ^ ODD;
  // most significant data bit of the word
  assign MSB = NINE ? WORD[8] : WORD[7];
  // received word passes when its top bit equals the computed parity
  assign OK = (MSB == PAR);
endmodule

// File: upssc_peer.sv
`timescale 1ns/10ps
// remote shift-register peripheral on the sync clock
module upssc_peer (
  // serial link
  input wire sclk,
  input wire txd,
  // clock options and clear
  input wire idle_lvl,
  input wire phase,
  input wire clr,
  // captured word
  output reg [8:0] bits,
  output reg [3:0] cnt
);
  reg last_q = 1'b0; // clock level at the previous event
  // sample mid-bit: leading edge in phase 0, trailing edge in phase 1
  always @(sclk or clr) begin
    if (clr) begin
      bits = 9'h000;
      cnt = 4'h0;
    end else if (sclk !== last_q && ((sclk != idle_lvl) ^ phase)) begin
      // one bit per pulse, lsb first
      bits[cnt] = txd;
      cnt = cnt + 4'h1;
    end
    last_q = sclk;
  end
endmodule

// File: upssc_properties.sv
`timescale 1ns/10ps
// checker on the top-level pins
module upssc_properties #(
  parameter BIT_CYCLES = 16
) (
  input wire MCLK,
  input wire SRST,
  input wire PSEL,
  input wire PENABLE,
  input wire [7:0] PADDR,
  input wire PSLVERR,
  input wire RX_ENABLE,
  input wire HALT_MODE,
  input wire IRQ_MASK,
  input wire IRQ,
  input wire WAKE_FROM_WAIT,
  input wire TXD_O,
  input wire TXD_OE,
  input wire SCLK_O,
  input wire SCLK_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////
  // two halted samples in a row
  sequence s_halted;
    HALT_MODE [*2];
  endsequence
  // receiver enabled for two samples
  sequence s_rx_held;
    RX_ENABLE [*2];
  endsequence
  ////////////////////////////////
  a_halt_pins_frozen: assert property (s_halted |-> $stable(TXD_O) && $stable(SCLK_O))
    else $error("serial pins moved in halt");
  a_halt_rx_stop: assert property (HALT_MODE |-> !RX_ENABLE)
    else $error("receiver running in halt");
  a_halt_no_wake: assert property (HALT_MODE |-> !WAKE_FROM_WAIT)
    else $error("wake raised in halt");
  a_wake_follows_irq: assert property (IRQ && !HALT_MODE |-> WAKE_FROM_WAIT)
    else $error("irq did not wake from wait");
  a_mask_blocks_irq: assert property (IRQ_MASK |-> !IRQ)
    else $error("irq seen while masked");
  a_pins_paired: assert property (TXD_OE == SCLK_OE)
    else $error("pin enables differ");
  a_rx_needs_pins: assert property (s_rx_held |-> TXD_OE)
    else $error("pins released with receiver on");
  a_reset_idle: assert property ($past(SRST) |-> TXD_O && !TXD_OE && !IRQ)
    else $error("pins or irq wrong after reset");
  a_bad_addr: assert property (PSEL && PENABLE && PADDR > 8'h10 |-> PSLVERR)
    else $error("unmapped access not flagged");
endmodule

bind upssc_top upssc_properties #(.BIT_CYCLES(BIT_CYCLES)) chk_u (.MCLK(MCLK), .SRST(SRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR), .RX_ENABLE(RX_ENABLE),
  .HALT_MODE(HALT_MODE), .IRQ_MASK(IRQ_MASK), .IRQ(IRQ), .WAKE_FROM_WAIT(WAKE_FROM_WAIT),
  .TXD_O(TXD_O), .TXD_OE(TXD_OE), .SCLK_O(SCLK_O), .SCLK_OE(SCLK_OE));

// File: upssc_top.v
`timescale 1ns/10ps
`include "upssc_map.vh"
module upssc_top #(
  parameter BIT_CYCLES = `UPSSC_BIT_CYCLES
) (
  // clock and reset
  input wire MCLK,
  input wire SRST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // receive shifter side
  input wire RX_WORD_VALID,
  input wire [8:0] RX_WORD,
  input wire RX_NOISE,
  input wire RX_FRAME_ERR,
  input wire RX_IDLE_DET,
  output wire RX_ENABLE,
  output wire RX_NINE,
  output reg ADDR_MARK,
  // power and interrupt
  input wire HALT_MODE,
  input wire IRQ_MASK,
  output wire IRQ,
  output wire WAKE_FROM_WAIT,
  // serial pins
  output reg TXD_O,
  output reg TXD_OE,
  output reg SCLK_O,
  output reg SCLK_OE
);
  //////////////////////////////////////////////////////////////////////////////
  // constants
  localparam [31:0] BIT_CYC = BIT_CYCLES; // bit length as a sized word
  localparam [15:0] BIT_LAST = BIT_CYC[15:0] - 16'h0001; // last cycle of a bit
  localparam [15:0] BIT_HALF = BIT_CYC[16:1]; // mid-bit point
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  localparam [1:0] ST_STOP = 2'h3;
  localparam [1:0] KD_DATA = 2'h0; // data frame
  localparam [1:0] KD_PRE = 2'h1; // idle preamble
  localparam [1:0] KD_BRK = 2'h2; // break frame
  // address decode, used for reads and writes
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `UPSSC_OFF_STATUS) || (a == `UPSSC_OFF_DATA) ||
        (a == `UPSSC_OFF_CTRL1) || (a == `UPSSC_OFF_CTRL2) || (a == `UPSSC_OFF_CTRL3);
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // state
  reg [7:0] status_q; // flag register
  reg [7:0] snap_q; // flags seen at last status read
  reg [4:0] ctrl1_q; // format and parity
  reg [7:0] ctrl2_q; // enables
  reg [2:0] ctrl3_q; // sync clock options
  reg [8:0] hold_q; // transmit holding word
  reg [8:0] rx_hold_q; // received word buffer
  reg quiet_arm_q; // idle flag may set
  reg pre_pend_q; // preamble owed
  reg [1:0] state_q; // transmitter state
  reg [1:0] kind_q; // current frame kind
  reg [8:0] sh_q; // transmit shifter
  reg [3:0] bidx_q; // data bit index
  reg [15:0] cyc_q; // cycle in bit

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire acc = PSEL & PENABLE; // access phase edge
  wire halted = HALT_MODE;
  wire act = acc & ~halted; // side effects allowed
  wire wr = act & PWRITE & is_mapped(PADDR);
  wire rd = act & ~PWRITE & is_mapped(PADDR);
  wire stat_rd = rd & (PADDR == `UPSSC_OFF_STATUS);
  wire data_wr = wr & (PADDR == `UPSSC_OFF_DATA);
  wire data_rd = rd & (PADDR == `UPSSC_OFF_DATA);
  // zero wait states; unmapped addresses report an error
  assign PREADY = 1'b1;
  assign PSLVERR = acc & ~is_mapped(PADDR);

  // control fields
  wire nine = ctrl1_q[`UPSSC_C1_NINE];
  wire par_on = ctrl1_q[`UPSSC_C1_PAR_ON];
  wire par_odd = ctrl1_q[`UPSSC_C1_PAR_ODD];
  wire tx_on = ctrl2_q[`UPSSC_C2_TX_ON];
  wire rx_on = ctrl2_q[`UPSSC_C2_RX_ON];
  wire idle_lvl = ctrl3_q[`UPSSC_C3_IDLE_LVL];
  wire phase_sel = ctrl3_q[`UPSSC_C3_PHASE];
  wire last_sel = ctrl3_q[`UPSSC_C3_LAST];
  // receiver settings
  // the receiver sees only its enable and the nine-bit format, never the clock options
  assign RX_ENABLE = rx_on & ~halted;
  assign RX_NINE = nine;
  //////////////////////////////////////////////////////////////////////////////
  // parity units
  wire tx_par;
  wire rx_msb;
  wire rx_ok;
  // transmit parity over holding word
  upssc_parity u_tx_par (
    .WORD(hold_q),
    .NINE(nine),
    .ODD(par_odd),
    .PAR(tx_par),
    .MSB(),
    .OK()
  );
  // receive parity over incoming word
  upssc_parity u_rx_par (
    .WORD(RX_WORD),
    .NINE(nine),
    .ODD(par_odd),
    .PAR(),
    .MSB(rx_msb),
    .OK(rx_ok)
  );
  // parity into msb
  // outgoing word with the top data bit replaced when parity is on
  wire [8:0] tx_word = !par_on ? hold_q :
    nine ? {tx_par, hold_q[7:0]} : {hold_q[8], tx_par, hold_q[6:0]};
  //////////////////////////////////////////////////////////////////////////////
  // transmitter timing
  wire bit_end = (cyc_q == BIT_LAST);
  wire [3:0] nbits = nine ? 4'h9 : 4'h8; // word length
  wire last_bit = (bidx_q == nbits - 4'h1);
  wire idle_go = (state_q == ST_IDLE) & tx_on;
  wire brk_req = ctrl2_q[`UPSSC_C2_BREAK];
  // move on not empty
  // a transfer needs the empty flag cleared by software first
  wire take_data = idle_go & ~pre_pend_q & ~brk_req &
    ~status_q[`UPSSC_ST_TX_EMPTY];
  wire frame_done = (state_q == ST_STOP) & bit_end;

  // transmitter state machine
  always @(posedge MCLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      kind_q <= KD_DATA;
      sh_q <= 9'h000;
      bidx_q <= 4'h0;
      cyc_q <= 16'h0000;
    end else if (!halted) begin
      // bit timer runs in every state but idle
      cyc_q <= (state_q == ST_IDLE || bit_end) ? 16'h0000 : cyc_q + 16'h0001;
      case (state_q)
        // wait for preamble, break or data
        ST_IDLE: begin
          bidx_q <= 4'h0;
          if (idle_go & pre_pend_q) begin
            kind_q <= KD_PRE;
            state_q <= ST_START;
          end else if (idle_go & brk_req) begin
            kind_q <= KD_BRK;
            state_q <= ST_START;
          end else if (take_data) begin
            kind_q <= KD_DATA;
            sh_q <= tx_word;
            state_q <= ST_START;
          end
        end
        // start bit
        ST_START: begin
          state_q <= bit_end ? ST_DATA : ST_START;
        end
        // data bits, lsb first
        ST_DATA: begin
          if (bit_end) begin
            sh_q <= {1'b0, sh_q[8:1]};
            bidx_q <= bidx_q + 4'h1;
            if (last_bit) begin
              state_q <= ST_STOP;
            end
          end
        end
        // stop bit
        ST_STOP: begin
          state_q <= bit_end ? ST_IDLE : ST_STOP;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // pin drive
  // data bits only
  wire pulse_win = (state_q == ST_DATA) & (kind_q == KD_DATA);
  wire pulse_en = pulse_win & (~last_bit | last_sel);
  wire first_half = (cyc_q < BIT_HALF);
  reg txd_n;
  // line level per state and frame kind
  always @* begin
    case (state_q)
      ST_START: txd_n = (kind_q == KD_PRE);
      ST_DATA: txd_n = (kind_q == KD_PRE) | ((kind_q == KD_DATA) & sh_q[0]);
      default: txd_n = 1'b1;
    endcase
  end
  // registered pins
  always @(posedge MCLK) begin
    if (SRST) begin
      TXD_O <= 1'b1;
      SCLK_O <= 1'b0;
      TXD_OE <= 1'b0;
      SCLK_OE <= 1'b0;
    end else if (!halted) begin
      TXD_O <= txd_n;
      SCLK_O <= idle_lvl ^ (pulse_en & (phase_sel ? first_half : ~first_half));
      TXD_OE <= tx_on | rx_on;
      SCLK_OE <= tx_on | rx_on;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // flag events
  wire rx_evt = RX_WORD_VALID & rx_on & ~halted;
  wire rx_full = status_q[`UPSSC_ST_RX_FULL];
  wire or_set = rx_evt & rx_full;
  wire rx_full_flag_set = rx_evt & ~rx_full;
  wire nf_set = rx_full_flag_set & RX_NOISE;
  wire fe_set = rx_full_flag_set & RX_FRAME_ERR;
  wire pe_set = rx_full_flag_set & par_on & ~rx_ok;
  wire idle_set = RX_IDLE_DET & rx_on & quiet_arm_q & ~halted;
  wire tc_set = frame_done & (kind_q == KD_DATA);
  wire [7:0] set_v = {take_data, tc_set, rx_full_flag_set, idle_set, or_set, nf_set, fe_set, pe_set};
  wire [7:0] clr_v = ({8{data_wr}} & snap_q & `UPSSC_TX_GROUP) |
    ({8{data_rd}} & snap_q & `UPSSC_RX_GROUP);

  // status, snapshot and receive buffer
  always @(posedge MCLK) begin
    if (SRST) begin
      status_q <= `UPSSC_STATUS_RST;
      snap_q <= 8'h00;
      rx_hold_q <= 9'h000;
      quiet_arm_q <= 1'b1;
      ADDR_MARK <= 1'b0;
    end else if (!halted) begin
      // set wins over a clear in the same cycle
      status_q <= (status_q & ~clr_v) | set_v;
      if (stat_rd) begin
        snap_q <= PRDATA[7:0]; // exactly the flags this read returned
      end else if (data_wr) begin
        snap_q <= snap_q & ~`UPSSC_TX_GROUP;
      end else if (data_rd) begin
        snap_q <= snap_q & ~`UPSSC_RX_GROUP;
      end
      if (rx_full_flag_set) begin
        rx_hold_q <= RX_WORD;
        ADDR_MARK <= rx_msb;
      end
      if (rx_full_flag_set) begin
        quiet_arm_q <= 1'b1;
      end else if (idle_set) begin
        quiet_arm_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers and holding word
  // frozen in halt
  always @(posedge MCLK) begin
    if (SRST) begin
      ctrl1_q <= 5'h00;
      ctrl2_q <= 8'h00;
      ctrl3_q <= 3'h0;
      hold_q <= 9'h000;
      pre_pend_q <= 1'b0;
    end else if (!halted) begin
      if (data_wr) begin
        hold_q <= PWDATA[8:0];
      end
      if (wr && PADDR == `UPSSC_OFF_CTRL1) begin
        ctrl1_q <= PWDATA[4:0];
      end
      if (wr && PADDR == `UPSSC_OFF_CTRL2) begin
        ctrl2_q <= PWDATA[7:0] & 8'hFD;
      end
      if (wr && PADDR == `UPSSC_OFF_CTRL3) begin
        ctrl3_q <= PWDATA[2:0];
      end
      // enabling the transmitter owes an idle frame
      if (wr && PADDR == `UPSSC_OFF_CTRL2 && PWDATA[`UPSSC_C2_TX_ON] && !tx_on) begin
        pre_pend_q <= 1'b1;
      end else if (idle_go) begin
        pre_pend_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data, loaded in the setup cycle
  always @(posedge MCLK) begin
    if (SRST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      case (PADDR)
        `UPSSC_OFF_STATUS: PRDATA <= {24'h000000, status_q};
        `UPSSC_OFF_DATA: PRDATA <= {23'h0, rx_hold_q};
        `UPSSC_OFF_CTRL1: PRDATA <= {27'h0, ctrl1_q};
        `UPSSC_OFF_CTRL2: PRDATA <= {24'h000000, ctrl2_q};
        `UPSSC_OFF_CTRL3: PRDATA <= {29'h0, ctrl3_q};
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt
  // shared request
  wire any_evt = (status_q[`UPSSC_ST_TX_EMPTY] & ctrl2_q[`UPSSC_C2_TX_EMPTY_IRQ]) |
    (status_q[`UPSSC_ST_TX_DONE] & ctrl2_q[`UPSSC_C2_TX_DONE_IRQ]) |
    ((status_q[`UPSSC_ST_RX_FULL] | status_q[`UPSSC_ST_OVERRUN]) &
      ctrl2_q[`UPSSC_C2_RX_IRQ]) |
    (status_q[`UPSSC_ST_QUIET] & ctrl2_q[`UPSSC_C2_QUIET_IRQ]) |
    (status_q[`UPSSC_ST_PARITY] & ctrl1_q[`UPSSC_C1_PAR_IRQ]);
  assign IRQ = any_evt & ~IRQ_MASK;
  assign WAKE_FROM_WAIT = IRQ & ~halted;
endmodule

// File: upssc_top_tb.sv
`timescale 1ns/10ps
`include "upssc_map.vh"
module upssc_top_tb;
  reg mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rd;
  reg rxv = 1'b0, rxn = 1'b0, rxf = 1'b0, rxi = 1'b0, halt = 1'b0, mask = 1'b0;
  reg [8:0] rxw = 9'h000, ex, m;
  reg idle = 1'b0, clr = 1'b1, serr, p;
  reg [3:0] c, n;
  wire [31:0] prdata;
  wire pready, pslverr, rx_en, am, irq, wake, txd, txd_oe, sclk, sclk_oe;
  wire [8:0] pbits;
  wire [3:0] pcnt;
  integer failures = 0, comparisons = 0, i, k;
  always #2.5 mclk = ~mclk;
  upssc_top #(.BIT_CYCLES(4)) dut_u (.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_WORD_VALID(rxv), .RX_WORD(rxw), .RX_NOISE(rxn), .RX_FRAME_ERR(rxf),
    .RX_IDLE_DET(rxi), .RX_ENABLE(rx_en), .RX_NINE(), .ADDR_MARK(am), .HALT_MODE(halt),
    .IRQ_MASK(mask), .IRQ(irq), .WAKE_FROM_WAIT(wake), .TXD_O(txd), .TXD_OE(txd_oe),
    .SCLK_O(sclk), .SCLK_OE(sclk_oe));
  upssc_peer peer_u (.sclk(sclk), .txd(txd), .idle_lvl(idle), .phase(c[1]), .clr(clr),
    .bits(pbits), .cnt(pcnt));
  ////////////////////////////////
  // apb transfer, held until pready
  task apb(input reg wr, input reg [7:0] a, input reg [31:0] wd);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // compare and count
  task chk(input reg [31:0] got, input reg [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one word or idle event from the receive shifter
  task rxp(input reg [8:0] w, input reg nz, input reg fr, input reg il);
    begin
      @(posedge mclk);
      rxv <= ~il;
      rxi <= il;
      rxw <= w;
      rxn <= nz;
      rxf <= fr;
      @(posedge mclk);
      rxv <= 1'b0;
      rxi <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task complete_run;
    begin
      if (failures == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////
  // watchdog
  initial begin
    #100000;
    failures = failures + 1;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000C0);
    apb(0, 8'h14, 0);
    chk({31'h0, serr}, 32'h1);
    // format table {nine, last, odd, idle}
    for (i = 0; i < 4; i = i + 1) begin
      c = 16'hDA70 >> (i * 4);
      clr <= 1'b1;
      apb(1, `UPSSC_OFF_CTRL2, 0);
      repeat (2) @(posedge mclk);
      chk({30'h0, txd_oe, sclk_oe}, 32'h0);
      idle <= c[0];
      apb(1, `UPSSC_OFF_CTRL3, {29'h0, c[0], c[1], c[2]});
      apb(1, `UPSSC_OFF_CTRL1, {27'h0, c[3], 2'b01, c[1], 1'b0});
      apb(1, `UPSSC_OFF_CTRL2, 32'h0C);
      chk({31'h0, sclk}, {31'h0, c[0]});
      clr <= 1'b0;
      apb(0, `UPSSC_OFF_STATUS, 0);
      apb(1, `UPSSC_OFF_DATA, 32'h1B5);
      apb(0, `UPSSC_OFF_STATUS, 0);
      chk({31'h0, rd[6]}, 32'h0);
      k = 0;
      while (rd[6] !== 1'b1 && k < 300) begin
        apb(0, `UPSSC_OFF_STATUS, 0);
        k = k + 1;
      end
      chk({31'h0, rd[6]}, 32'h1);
      n = 4'd7 + c[3] + c[2];
      p = (c[3] ? ^8'hB5 : ^7'h35) ^ c[1];
      ex = c[3] ? {p, 8'hB5} : {1'b0, p, 7'h35};
      m = ~(9'h1FF << n);
      chk({28'h0, pcnt}, {28'h0, n});
      chk({23'h0, pbits & m}, {23'h0, ex & m});
    end
    rxp(9'h0B5, 1, 0, 0);
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000E5);
    chk({31'h0, am}, 32'h0);
    rxp(9'h1FF, 0, 1, 0);
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000ED);
    apb(1, `UPSSC_OFF_CTRL2, 32'h2C);
    @(posedge mclk);
    chk({30'h0, irq, wake}, 32'h3);
    mask <= 1'b1;
    halt <= 1'b1;
    apb(1, `UPSSC_OFF_CTRL2, 0);
    chk({30'h0, irq, rx_en}, 32'h0);
    halt <= 1'b0;
    mask <= 1'b0;
    @(posedge mclk);
    chk({31'h0, rx_en}, 32'h1);
    apb(0, `UPSSC_OFF_DATA, 0);
    chk(rd, 32'h000000B5);
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000C0);
    rxp(0, 0, 0, 1);
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000D0);
    apb(0, `UPSSC_OFF_DATA, 0);
    rxp(0, 0, 0, 1);
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000C0);
    rxp(9'h1B5, 0, 0, 0);
    apb(0, `UPSSC_OFF_DATA, 0);
    chk(rd, 32'h000001B5);
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000E0);
    chk({31'h0, am}, 32'h1);
    rxp(0, 0, 0, 1);
    apb(0, `UPSSC_OFF_STATUS, 0);
    chk(rd, 32'h000000F0);
    complete_run;
  end
endmodule
